// *** design/ext_irq_pkg.sv ***
// Summary of operation
// (R01) Pin A trigger: 00 rising, 01 falling, 10 both edges, 11 high level.
// (R02) Each pin A request captures the filtered level for software to read.
// (R03) In both-edge mode the captured level shows rising (1) or falling (0).
// (R04) Fast modes: new pin A level accepted after three consecutive matching samples.
// (R05) Fast sampling interval: 00 every clock, 01 every 4, 10 every 8, 11 every 16.
// (R06) Slow modes: sample at low-frequency clock divided by 4, accept after two.
// (R07) Deep idle, deep sleep and stop halt sampling and raise no request.
// (R08) Software disables the source before turning its pin into an output.
// (R09) Software disables each source before changing the operating mode.
// (R10) After fast-to-slow change software waits twelve low-frequency periods, clears latch.
// (R11) After slow-to-fast change software waits two clocks plus three intervals.
// (R12) Software picks the sampling interval to suit the expected noise period.
// (R13) Pin B raises a request only on a falling edge of its filtered input.
// (R14) Pin B fast: reject under one clock, accept two clocks or longer.
// (R15) Pin B slow: reject under four, accept eight low-frequency periods or longer.
// (R16) Clock enable 0 stops the logic and requests; it resets to 0.
// (R17) The captured level is overwritten on every new request.
// (R18) Edges compare current and previous level; high mode requests on every sample of a high level.
package ext_irq_pkg;

  typedef enum logic [2:0] {
    MODE_FAST_RUN,
    MODE_FAST_IDLE,
    MODE_SLOW_RUN,
    MODE_SLOW_SLEEP,
    MODE_DEEP_IDLE,
    MODE_DEEP_SLEEP,
    MODE_STOP
  } mode_t;

  // Register map
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;

  // Control fields
  localparam int CTRL_CLKEN_BIT = 0;
  localparam int CTRL_TRIG_LSB = 1;
  localparam int CTRL_NC_LSB = 3;
  localparam logic CLKEN_RST = 1'b0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [1:0] NC_RST = 2'h0;

  // Status fields
  localparam int STAT_CAP_BIT = 0;
  localparam int STAT_LVLA_BIT = 1;
  localparam int STAT_LVLB_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 3;

  // Trigger codes
  localparam logic [1:0] TRIG_RISE = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_BOTH = 2'h2;
  localparam logic [1:0] TRIG_HIGH = 2'h3;

  // Sampling interval codes
  localparam logic [1:0] NC_DIV1 = 2'h0;
  localparam logic [1:0] NC_DIV4 = 2'h1;
  localparam logic [1:0] NC_DIV8 = 2'h2;
  localparam logic [1:0] NC_DIV16 = 2'h3;

  // Filter sample counts and low-frequency divider
  localparam logic [1:0] FAST_NEED = 2'h3;
  localparam logic [1:0] SLOW_NEED = 2'h2;
  localparam logic [1:0] LF_DIV_LAST = 2'h3;

  // AHB-Lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** design/filt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface filt_if;
  logic sample_en;
  logic raw;
  logic [1:0] need;
  logic level;
  modport ctrl (output sample_en, output raw, output need, input level);
  modport filt (input sample_en, input raw, input need, output level);
endinterface
`default_nettype wire

// *** design/noise_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module noise_filter
  import ext_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filter port
  filt_if.filt f
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic level_q;
  logic level_d;

  // =====================================================
  // Consecutive-sample filter
  wire logic [1:0] cnt_inc = cnt_q + 2'h1;
  wire logic match = (f.raw == level_q);
  wire logic done = (cnt_inc == f.need);

  assign cnt_d = !f.sample_en ? cnt_q : (match || done) ? 2'h0 : cnt_inc;
  assign level_d = (f.sample_en && !match && done) ? f.raw : level_q; // R04
  assign f.level = level_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 2'h0;
      level_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      level_q <= level_d;
    end
  end

  // =====================================================
  // Checks
  accept_count_a: assert property (@(posedge clk) disable iff (rst) // R04
    $changed(level_q) |-> $past(f.sample_en)
      && ($past(cnt_q) + 2'h1 == $past(f.need)))
    else $error("Level accepted without the full sample count");

  accept_value_a: assert property (@(posedge clk) disable iff (rst) // R06
    $changed(level_q) |-> level_q == $past(f.raw))
    else $error("Accepted level differs from the last sample");

endmodule
`default_nettype wire

// *** design/ext_irq_filter_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_irq_filter_edge_detect
  import ext_irq_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Power state
  input wire logic [2:0] PWR_MODE,
  input wire logic LF_CLK_EN,
  // Interrupt pins
  input wire logic EXT_IRQ_PIN_A,
  input wire logic EXT_IRQ_PIN_B,
  // Requests to the interrupt latch
  output logic IRQ_A_REQ,
  output logic IRQ_B_REQ
);

  // =====================================================
  // Control and status registers
  logic clk_en_q;
  logic clk_en_d;
  logic [1:0] trig_q;
  logic [1:0] trig_d;
  logic [1:0] nc_q;
  logic [1:0] nc_d;
  logic cap_q;
  logic cap_d;
  logic req_a_q;
  logic req_b_q;
  logic a_prev_q;
  logic b_prev_q;
  logic [3:0] div_q;
  logic [1:0] lf_q;
  logic [1:0] lf_d;

  // Bus state
  logic wr_q;
  logic [31:0] waddr_q;
  logic [31:0] rdata_q;

  filt_if fa ();
  filt_if fb ();

  // =====================================================
  // Operating mode decode
  wire mode_t mode = mode_t'(PWR_MODE);
  wire logic fast = (mode == MODE_FAST_RUN) || (mode == MODE_FAST_IDLE);
  wire logic slow = (mode == MODE_SLOW_RUN) || (mode == MODE_SLOW_SLEEP);
  wire logic active = clk_en_q && (fast || slow); // R07 R16

  // =====================================================
  // Sample enables
  wire logic lf_tick = LF_CLK_EN && (lf_q == LF_DIV_LAST); // R06
  wire logic t4 = (div_q[1:0] == 2'h0);
  wire logic t8 = (div_q[2:0] == 3'h0);
  wire logic t16 = (div_q == 4'h0);
  wire logic fast_tick =
    (nc_q == NC_DIV1) ? 1'b1 :
    (nc_q == NC_DIV4) ? t4 :
    (nc_q == NC_DIV8) ? t8 : t16; // R05
  wire logic a_smp = active && (fast ? fast_tick : lf_tick); // R05 R06 R07
  wire logic b_smp = active && (fast ? 1'b1 : lf_tick); // R14 R15

  assign lf_d = (active && slow && LF_CLK_EN) ? lf_q + 2'h1 : lf_q;

  // =====================================================
  // Filters
  assign fa.sample_en = a_smp;
  assign fa.raw = EXT_IRQ_PIN_A;
  assign fa.need = fast ? FAST_NEED : SLOW_NEED; // R04 R06
  assign fb.sample_en = b_smp;
  assign fb.raw = EXT_IRQ_PIN_B;
  assign fb.need = SLOW_NEED; // R14 R15

  noise_filter u_filt_a (
    .clk(REF_CLK),
    .rst(RST),
    .f(fa.filt)
  );

  noise_filter u_filt_b (
    .clk(REF_CLK),
    .rst(RST),
    .f(fb.filt)
  );

  wire logic a_lvl = fa.level;
  wire logic b_lvl = fb.level;

  // =====================================================
  // Request generation
  wire logic a_rise = a_lvl && !a_prev_q; // R18
  wire logic a_fall = !a_lvl && a_prev_q; // R18
  wire logic b_fall = !b_lvl && b_prev_q; // R13
  wire logic a_cond =
    (trig_q == TRIG_RISE) ? a_rise :
    (trig_q == TRIG_FALL) ? a_fall :
    (trig_q == TRIG_BOTH) ? (a_rise || a_fall) :
    (a_smp && a_lvl); // R01 R18
  wire logic a_hit = active && a_cond; // R07 R16
  wire logic b_hit = active && b_fall; // R13

  assign cap_d = a_hit ? a_lvl : cap_q; // R02 R03 R17

  // =====================================================
  // AHB-Lite decode
  wire logic addr_ok = HSEL && HREADY && HTRANS[1];
  wire logic wr_ctrl = wr_q && (waddr_q == CTRL_OFS);

  assign clk_en_d = wr_ctrl ? HWDATA[CTRL_CLKEN_BIT] : clk_en_q;
  assign trig_d = wr_ctrl ? HWDATA[CTRL_TRIG_LSB +: 2] : trig_q;
  assign nc_d = wr_ctrl ? HWDATA[CTRL_NC_LSB +: 2] : nc_q;

  wire logic [31:0] ctrl_word =
    {27'h0, nc_d, trig_d, clk_en_d};
  wire logic [31:0] stat_word =
    {28'h0, active, b_lvl, a_lvl, cap_d}; // R02
  wire logic [31:0] rd_word =
    (HADDR == CTRL_OFS) ? ctrl_word :
    (HADDR == STAT_OFS) ? stat_word : 32'h0000_0000;

  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;
  assign HRDATA = rdata_q;
  assign IRQ_A_REQ = req_a_q;
  assign IRQ_B_REQ = req_b_q;

  // =====================================================
  // Bus registers
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_q <= 1'b0;
      waddr_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= addr_ok && HWRITE && (HSIZE == HSIZE_WORD);
      waddr_q <= addr_ok ? HADDR : waddr_q;
      rdata_q <= (addr_ok && !HWRITE) ? rd_word : rdata_q;
    end
  end

  // =====================================================
  // Control registers
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      clk_en_q <= CLKEN_RST; // R16
      trig_q <= TRIG_RST;
      nc_q <= NC_RST;
    end
    else
    begin
      clk_en_q <= clk_en_d;
      trig_q <= trig_d;
      nc_q <= nc_d;
    end
  end

  // =====================================================
  // Dividers, edge history and requests
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      div_q <= 4'h0;
      lf_q <= 2'h0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      cap_q <= 1'b0;
      req_a_q <= 1'b0;
      req_b_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 4'h1;
      lf_q <= lf_d;
      a_prev_q <= a_lvl;
      b_prev_q <= b_lvl;
      cap_q <= cap_d; // R17
      req_a_q <= a_hit;
      req_b_q <= b_hit;
    end
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  rise_trigger_a: assert property ( // R01
    active && trig_q == TRIG_RISE && a_rise |=> IRQ_A_REQ)
    else $error("Rising edge gave no request");

  fall_only_a: assert property ( // R01
    IRQ_A_REQ && $past(trig_q) == TRIG_FALL |-> !cap_q ##1 !IRQ_A_REQ)
    else $error("Falling mode request on a high level");

  level_capture_a: assert property ( // R02
    IRQ_A_REQ |-> cap_q == $past(a_lvl))
    else $error("Captured level does not match filter output");

  both_edge_a: assert property ( // R03
    IRQ_A_REQ && $past(trig_q) == TRIG_BOTH |-> cap_q == $past(a_rise))
    else $error("Captured level does not show the edge");

  interval_16_a: assert property ( // R05
    a_smp && fast && nc_q == NC_DIV16 |-> ##[1:16] a_smp || !active)
    else $error("Sixteen-clock interval missed");

  slow_rate_a: assert property ( // R06
    a_smp && slow |-> $past(lf_q) == 2'h2 || lf_q == LF_DIV_LAST)
    else $error("Slow sample not on divided tick");

  deep_halt_a: assert property ( // R07
    !(fast || slow) |-> !a_smp && !b_smp ##1 !IRQ_A_REQ && !IRQ_B_REQ)
    else $error("Activity in a halted mode");

  b_fall_only_a: assert property ( // R13
    IRQ_B_REQ |-> $past(b_prev_q) && !$past(b_lvl))
    else $error("Pin B request without a falling edge");

  b_fast_pulse_a: assert property ( // R14
    fast && active && !EXT_IRQ_PIN_B ##1 EXT_IRQ_PIN_B && b_lvl
      ##1 EXT_IRQ_PIN_B |-> ##1 b_lvl)
    else $error("One-clock low pulse passed the pin B filter");

  clk_off_a: assert property ( // R16
    !clk_en_q |=> !IRQ_A_REQ && !IRQ_B_REQ)
    else $error("Request raised with the clock disabled");

  high_repeat_a: assert property ( // R18
    active && trig_q == TRIG_HIGH && a_smp && a_lvl |=> IRQ_A_REQ)
    else $error("High level sample gave no request");

  // =====================================================
  // Register and request checks

  ctrl_write_a: assert property ( // R01 R05 R16
    wr_ctrl |=> clk_en_q == $past(HWDATA[CTRL_CLKEN_BIT])
      && trig_q == $past(HWDATA[CTRL_TRIG_LSB +: 2])
      && nc_q == $past(HWDATA[CTRL_NC_LSB +: 2]))
    else $error("Control write not applied");

  ctrl_hold_a: assert property ( // R16
    !wr_ctrl |=> $stable(clk_en_q) && $stable(trig_q) && $stable(nc_q))
    else $error("Control field changed without a write");

  read_hold_a: assert property (
    !(addr_ok && !HWRITE) |=> $stable(HRDATA))
    else $error("Read data changed without a read");

  stat_read_a: assert property ( // R02
    addr_ok && !HWRITE && HADDR == STAT_OFS
      |=> HRDATA[STAT_CAP_BIT] == cap_q
      && HRDATA[STAT_LVLA_BIT] == $past(a_lvl)
      && HRDATA[STAT_ACTIVE_BIT] == $past(active))
    else $error("Status read does not show the live state");

  ctrl_read_a: assert property ( // R16
    addr_ok && !HWRITE && HADDR == CTRL_OFS
      |=> HRDATA[CTRL_CLKEN_BIT] == clk_en_q
      && HRDATA[CTRL_NC_LSB +: 2] == nc_q)
    else $error("Control read does not show the fields");

  a_single_a: assert property ( // R18
    IRQ_A_REQ && trig_q != TRIG_HIGH |=> !IRQ_A_REQ)
    else $error("Edge request lasted more than one cycle");

  b_single_a: assert property ( // R13
    IRQ_B_REQ |=> !IRQ_B_REQ)
    else $error("Pin B request lasted more than one cycle");

  cap_source_a: assert property ( // R17
    $changed(cap_q) |-> IRQ_A_REQ)
    else $error("Captured level changed without a request");

  a_hold_a: assert property ( // R05 R06 R07
    !$past(a_smp) |-> $stable(a_lvl))
    else $error("Pin A level moved between samples");

  b_hold_a: assert property ( // R14 R15 R16
    !$past(b_smp) |-> $stable(b_lvl))
    else $error("Pin B level moved between samples");

  lf_hold_a: assert property ( // R06
    !(active && slow && LF_CLK_EN) |=> $stable(lf_q))
    else $error("Low-frequency divider moved without a pulse");

  fast_b_a: assert property ( // R14
    fast && active |-> b_smp)
    else $error("Pin B missed a fast sample");

  rise_capture_a: assert property ( // R02 R03
    IRQ_A_REQ && $past(trig_q) == TRIG_RISE |-> cap_q)
    else $error("Rising request captured a low level");

  fall_trigger_a: assert property ( // R01
    active && trig_q == TRIG_FALL && a_fall |=> IRQ_A_REQ && !cap_q)
    else $error("Falling edge gave no request");

  b_trigger_a: assert property ( // R13
    active && b_fall |=> IRQ_B_REQ)
    else $error("Pin B falling edge gave no request");

  both_trigger_a: assert property ( // R01 R03
    active && trig_q == TRIG_BOTH && (a_rise || a_fall)
      |=> IRQ_A_REQ && cap_q == $past(a_rise))
    else $error("Both-edge mode missed an edge");

  both_edge_c: cover property (
    IRQ_A_REQ && trig_q == TRIG_BOTH && !cap_q);
  high_level_c: cover property (
    IRQ_A_REQ && trig_q == TRIG_HIGH ##1 IRQ_A_REQ);
  b_request_c: cover property (IRQ_B_REQ && fast);
  slow_request_c: cover property (IRQ_A_REQ && slow);
  fast_interval_c: cover property (a_smp && fast && nc_q == NC_DIV16);

endmodule
`default_nettype wire

// *** testbench/pin_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======
// External pin sources
module pin_source
(
  // Clock
  input wire logic clk,
  // Pins
  output logic pin_a,
  output logic pin_b
);
  // Pins stay inputs, never forced low as outputs
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b1;
  end
  // Hold a level for n cycles; glitches stay isolated
  task drive(input logic sel_b, input logic v, input int n);
    if (sel_b)
      pin_b <= v;
    else
      pin_a <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/ext_irq_filter_edge_detect_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======
// Bench
module ext_irq_filter_edge_detect_bench;
  import ext_irq_pkg::*;
  logic REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, LF_CLK_EN;
  logic IRQ_A_REQ, IRQ_B_REQ, pin_a, pin_b;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, lf_cnt;
  logic [2:0] HSIZE, PWR_MODE;
  int failures, compares, cycles, na, nb, a0, b0;

  ext_irq_filter_edge_detect uut (.REF_CLK(REF_CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PWR_MODE(PWR_MODE),
    .LF_CLK_EN(LF_CLK_EN), .EXT_IRQ_PIN_A(pin_a), .EXT_IRQ_PIN_B(pin_b),
    .IRQ_A_REQ(IRQ_A_REQ), .IRQ_B_REQ(IRQ_B_REQ));
  pin_source src (.clk(REF_CLK), .pin_a(pin_a), .pin_b(pin_b));

  initial
  begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  // ======
  // Request counters, low-frequency enable, timeout
  always @(posedge REF_CLK)
  begin
    cycles++;
    lf_cnt <= lf_cnt + 2'h1;
    LF_CLK_EN <= (lf_cnt == 2'h3);
    if (cycles == 20000)
    begin
      failures++;
      print_verdict;
    end
  end

  // Requests counted mid-cycle, away from the launching edge
  always @(negedge REF_CLK)
  begin
    na += (IRQ_A_REQ === 1'b1);
    nb += (IRQ_B_REQ === 1'b1);
  end

  task print_verdict;
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ======
  // AHB-Lite single word transfer
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    HSEL <= 1'b1;
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'h2;
    HSIZE <= HSIZE_WORD;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  task cfg(input logic en, input logic [1:0] trig, input logic [1:0] nc);
    bus(1'b1, CTRL_OFS, {27'h0, nc, trig, en}, rd);
  endtask

  task mark;
    a0 = na;
    b0 = nb;
  endtask

  task mode(input logic [2:0] m);
    cfg(1'b0, TRIG_RISE, NC_DIV1);
    PWR_MODE <= m;
    repeat (48) @(posedge REF_CLK);
    cfg(1'b1, TRIG_RISE, NC_DIV1);
  endtask

  // ======
  // Scenarios
  task t_reset;
    bus(1'b0, CTRL_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b1, 32'h8, 32'hffff_ffff, rd);
    bus(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'b0, STAT_OFS, 32'h0, rd);
    chk(rd, 32'h0);
    chk(HRESP, HRESP_OKAY);
  endtask

  task t_off;
    mark;
    src.drive(1'b0, 1'b1, 20);
    src.drive(1'b0, 1'b0, 20);
    src.drive(1'b1, 1'b0, 20);
    src.drive(1'b1, 1'b1, 20);
    chk(na - a0, 0);
    chk(nb - b0, 0);
  endtask

  task t_trig;
    for (int i = 0; i < 3; i++)
    begin
      cfg(1'b1, i[1:0], NC_DIV1);
      repeat (10) @(posedge REF_CLK);
      mark;
      src.drive(1'b0, 1'b1, 20);
      chk(na - a0, i != 1);
      bus(1'b0, STAT_OFS, 32'h0, rd);
      if (i != 1)
        chk(rd[0], 1'b1);
      mark;
      src.drive(1'b0, 1'b0, 20);
      chk(na - a0, i != 0);
      bus(1'b0, STAT_OFS, 32'h0, rd);
      if (i != 0)
        chk(rd[0], 1'b0);
    end
  endtask

  task t_high;
    cfg(1'b1, TRIG_HIGH, NC_DIV1);
    mark;
    src.drive(1'b0, 1'b1, 20);
    src.drive(1'b0, 1'b0, 20);
    chk(na - a0 > 10, 1);
    mark;
    repeat (10) @(posedge REF_CLK);
    chk(na - a0, 0);
  endtask

  task t_fast;
    int p;
    for (int i = 0; i < 4; i++)
    begin
      p = (i == 0) ? 1 : (1 << (i + 1));
      cfg(1'b1, TRIG_RISE, i[1:0]);
      bus(1'b0, CTRL_OFS, 32'h0, rd);
      chk(rd, {27'h0, i[1:0], TRIG_RISE, 1'b1});
      mark;
      src.drive(1'b0, 1'b1, 2 * p);
      src.drive(1'b0, 1'b0, 4 * p + 8);
      chk(na - a0, 0);
      mark;
      src.drive(1'b0, 1'b1, 4 * p);
      src.drive(1'b0, 1'b0, 4 * p + 8);
      chk(na - a0, 1);
    end
  endtask

  task t_pin_b;
    bus(1'b0, STAT_OFS, 32'h0, rd);
    chk(rd[STAT_ACTIVE_BIT], 1'b1);
    chk(rd[STAT_LVLB_BIT], 1'b1);
    mark;
    src.drive(1'b1, 1'b0, 1);
    src.drive(1'b1, 1'b1, 10);
    chk(nb - b0, 0);
    mark;
    src.drive(1'b1, 1'b0, 2);
    src.drive(1'b1, 1'b1, 10);
    chk(nb - b0, 1);
  endtask

  task t_slow;
    mark;
    src.drive(1'b1, 1'b0, 12);
    src.drive(1'b1, 1'b1, 40);
    src.drive(1'b0, 1'b1, 12);
    src.drive(1'b0, 1'b0, 40);
    chk(nb - b0, 0);
    chk(na - a0, 0);
    mark;
    src.drive(1'b1, 1'b0, 32);
    src.drive(1'b1, 1'b1, 40);
    src.drive(1'b0, 1'b1, 32);
    src.drive(1'b0, 1'b0, 40);
    chk(nb - b0, 1);
    chk(na - a0, 1);
  endtask

  task t_deep;
    bus(1'b0, STAT_OFS, 32'h0, rd);
    chk(rd[STAT_ACTIVE_BIT], 1'b0);
    mark;
    src.drive(1'b0, 1'b1, 40);
    src.drive(1'b0, 1'b0, 40);
    src.drive(1'b1, 1'b0, 40);
    src.drive(1'b1, 1'b1, 40);
    chk(na - a0, 0);
    chk(nb - b0, 0);
  endtask

  // ======
  // Main sequence
  initial
  begin
    RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = HSIZE_WORD;
    HWDATA = 32'h0;
    PWR_MODE = MODE_FAST_RUN;
    LF_CLK_EN = 1'b0;
    lf_cnt = 2'h0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    t_reset;
    t_off;
    t_trig;
    t_high;
    t_fast;
    mode(MODE_FAST_IDLE);
    t_pin_b;
    mode(MODE_SLOW_RUN);
    t_slow;
    mode(MODE_SLOW_SLEEP);
    t_slow;
    mode(MODE_DEEP_IDLE);
    t_deep;
    mode(MODE_DEEP_SLEEP);
    t_deep;
    mode(MODE_STOP);
    t_deep;
    mode(MODE_FAST_RUN);
    t_pin_b;
    print_verdict;
  end
endmodule
`default_nettype wire
